//--- logic/boot_loader_pkg.sv
// Shared constants and types for the reset, PLL and boot loader block.
// Contract
// - Device stays reset while chip_hold_low_n low.
// - GPIO pull-downs enabled during reset.
// - Boot begins 15-150 us after reset release.
// - Security bit 5 selects OTP, else flash.
// - Security register loaded from OTP first.
// - Secure boot executes OTP address zero.
// - Flash image read through tile 0 ports.
// - Image starts with 32-bit word length.
// - Trailer is CRC or skip value.
// - Length and trailer are LSB first.
// - Program loads and starts at lowest RAM.
// - CRC covers length word and program bytes.
// - Reflected poly, all-ones start, inverted result.
// - Select pins choose PLL ratio 40/16/8/4.
// - Feedback 159/63/31/15, post 1, input 0.
// - Tile clock follows feedback and divider formula.
// - PLL fields writable at run time.
package boot_loader_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_SEQ_MIN_US = 15;
	localparam int RESET_SEQ_CYC = (RESET_SEQ_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SECURE_BOOT_BIT = 5;
	localparam int OTP_ADDR_W = 11;
	localparam logic [10:0] OTP_SEC_ADDR = 11'h7FF;
	localparam logic [10:0] OTP_EXEC_ADDR = 11'h000;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
	localparam logic [31:0] SEC_RESET = 32'h00000000;
	localparam logic [2:0] PLL_POST_DIV_BOOT = 3'h1;
	localparam logic [5:0] PLL_IN_DIV_BOOT = 6'h00;
	localparam logic [11:0] PLL_FB_SEL00 = 12'h09F;
	localparam logic [11:0] PLL_FB_SEL11 = 12'h03F;
	localparam logic [11:0] PLL_FB_SEL10 = 12'h01F;
	localparam logic [11:0] PLL_FB_SEL01 = 12'h00F;
	localparam logic [5:0] PLL_RATIO_SEL00 = 6'h28;
	localparam logic [5:0] PLL_RATIO_SEL11 = 6'h10;
	localparam logic [5:0] PLL_RATIO_SEL10 = 6'h08;
	localparam logic [5:0] PLL_RATIO_SEL01 = 6'h04;
	localparam logic [11:0] PLL_FB_RESET = 12'h09F;
	localparam logic [5:0] PLL_RATIO_RESET = 6'h28;
	localparam int PIN_HOLD = 0;
	localparam int PIN_SEL0 = 1;
	localparam int PIN_SEL1 = 2;
	localparam int PIN_TILE2 = 3;
	localparam int PIN_LOW_A = 4;
	localparam int PIN_LOW_C = 6;
	localparam logic [6:0] PINS_RESET = 7'h00;

	typedef enum logic [3:0] {
		ST_HOLD = 4'b0000,
		ST_RSTSEQ = 4'b0001,
		ST_SECREQ = 4'b0010,
		ST_CHOOSE = 4'b0011,
		ST_LEN = 4'b0100,
		ST_PROG = 4'b0101,
		ST_TRAIL = 4'b0110,
		ST_RUN = 4'b0111,
		ST_ERR = 4'b1000
	} state_e;
endpackage

//--- logic/crc32_byte.sv
// One byte step of the reflected CRC-32 used to check the boot image.
`timescale 1ns/1ps
`default_nettype none
module crc32_byte
	import boot_loader_pkg::*;
(
	// Running value and next byte.
	input wire logic [31:0] crcIn,
	input wire logic [7:0] dataByte,
	// Updated value.
	output logic [31:0] crcOut
);
	// Bits enter least significant first, which is why the polynomial is reflected.
	always_comb
	begin
		crcOut = crcIn;
		for (int i = 0; i < 8; i++)
		begin
			if (crcOut[0] ^ dataByte[i])
			begin
				crcOut = (crcOut >> 1) ^ CRC_POLY;
			end
			else
			begin
				crcOut = crcOut >> 1;
			end
		end
	end
endmodule
`default_nettype wire

//--- logic/boot_ram.sv
// Tile RAM that receives the boot image, with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module boot_ram #(
	parameter int ADDR_W = 10
) (
	// Clock.
	input wire logic clk_sys,
	// Loader write port.
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [31:0] wrData,
	// Core read port.
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [31:0] rdData
);
	logic [31:0] mem [0:(1 << ADDR_W) - 1];

	// Memory contents have no reset; the core only reads what the loader wrote.
	always_ff @(posedge clk_sys)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule
`default_nettype wire

//--- logic/reset_pll_boot_loader.sv
// Chip reset, strap capture, PLL start values and boot image loader for one tile.
`timescale 1ns/1ps
`default_nettype none
module reset_pll_boot_loader
	import boot_loader_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	// Clock and power-on reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Chip pins.
	input wire logic chip_hold_low_n,
	input wire logic pll_select_bit0,
	input wire logic pll_select_bit1,
	input wire logic tile2_link_boot_strap,
	input wire logic strap_low_a,
	input wire logic strap_low_b,
	input wire logic strap_low_c,
	// Reset state seen by the rest of the tile.
	output logic coreResetN,
	output logic gpioPullDownEn,
	output logic tile2LinkBoot,
	output logic strapFault,
	// PLL settings.
	output logic [2:0] pll_post_divider,
	output logic [11:0] pll_feedback_value,
	output logic [5:0] pll_input_divider,
	output logic [5:0] pllBootRatio,
	// Run-time PLL configuration write.
	input wire logic pllCfgWe,
	input wire logic [2:0] pllCfgPostDivider,
	input wire logic [11:0] pllCfgFeedbackValue,
	input wire logic [5:0] pllCfgInputDivider,
	// OTP read port.
	output logic otpReadReq,
	output logic [OTP_ADDR_W-1:0] otpAddr,
	input wire logic otpReadValid,
	input wire logic [31:0] otpReadData,
	// Flash byte stream from the tile 0 ports.
	output logic flashReadEn,
	input wire logic flashByteValid,
	input wire logic [7:0] flashByte,
	// Boot result.
	output logic bootRun,
	output logic bootFromOtp,
	output logic [31:0] execAddr,
	output logic bootError,
	output logic [31:0] securityReg,
	// Core read port into the loaded RAM.
	input wire logic [ADDR_W-1:0] coreRdAddr,
	output logic [31:0] coreRdData
);
	generate
		if (ADDR_W < 2 || ADDR_W > 20)
		begin : g_bad_width
			$error("ADDR_W must lie between 2 and 20");
		end
	endgenerate

	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [6:0] sync3;
		logic [6:0] pins;
		state_e state;
		logic [15:0] cnt;
		logic [1:0] byteCnt;
		logic [31:0] word;
		logic [31:0] wordsLeft;
		logic [ADDR_W-1:0] addr;
		logic [31:0] crc;
		logic [31:0] secReg;
		logic coreResetN;
		logic gpioPd;
		logic tile2Link;
		logic strapFault;
		logic [2:0] postDiv;
		logic [11:0] feedback;
		logic [5:0] inDiv;
		logic [5:0] ratio;
		logic otpReq;
		logic flashEn;
		logic ramWe;
		logic [ADDR_W-1:0] ramWaddr;
		logic [31:0] ramWdata;
		logic run;
		logic fromOtp;
		logic err;
	} loader_s;

	localparam loader_s LOADER_RESET = '{
		sync1: PINS_RESET, sync2: PINS_RESET, sync3: PINS_RESET, pins: PINS_RESET,
		state: ST_HOLD, cnt: 16'h0000, byteCnt: 2'h0, word: 32'h00000000,
		wordsLeft: 32'h00000000, addr: '0, crc: CRC_INIT, secReg: SEC_RESET,
		coreResetN: 1'b0, gpioPd: 1'b1, tile2Link: 1'b0, strapFault: 1'b0,
		postDiv: PLL_POST_DIV_BOOT, feedback: PLL_FB_RESET, inDiv: PLL_IN_DIV_BOOT,
		ratio: PLL_RATIO_RESET, otpReq: 1'b0, flashEn: 1'b0, ramWe: 1'b0,
		ramWaddr: '0, ramWdata: 32'h00000000, run: 1'b0, fromOtp: 1'b0, err: 1'b0
	};
	localparam logic [31:0] RAM_WORDS = 32'(1 << ADDR_W);

	loader_s q;
	loader_s d;
	logic [6:0] pinRaw;
	logic [31:0] crcNext;
	logic [31:0] wordNext;

	assign pinRaw = {strap_low_c, strap_low_b, strap_low_a, tile2_link_boot_strap,
		pll_select_bit1, pll_select_bit0, chip_hold_low_n};
	// Length and trailer arrive least significant byte first.
	assign wordNext = {flashByte, q.word[31:8]};

	crc32_byte u_crc (
		.crcIn(q.crc),
		.dataByte(flashByte),
		.crcOut(crcNext)
	);

	boot_ram #(
		.ADDR_W(ADDR_W)
	) u_ram (
		.clk_sys(clk_sys),
		.wrEn(q.ramWe),
		.wrAddr(q.ramWaddr),
		.wrData(q.ramWdata),
		.rdAddr(coreRdAddr),
		.rdData(coreRdData)
	);

	always_comb
	begin
		d = q;
		d.ramWe = 1'b0;
		{d.sync3, d.sync2, d.sync1} = {q.sync2, q.sync1, pinRaw};
		// A pin only changes once two settled samples agree, so a glitch is ignored.
		d.pins = (q.sync2 & q.sync3) | (q.pins & (q.sync2 | q.sync3));
		// Run-time PLL writes; software keeps the values within the legal VCO range.
		if (pllCfgWe && q.state != ST_HOLD)
		begin
			d.postDiv = pllCfgPostDivider;
			d.feedback = pllCfgFeedbackValue;
			d.inDiv = pllCfgInputDivider;
		end
		case (q.state)
			ST_HOLD:
			begin
				if (q.pins[PIN_HOLD])
				begin
					d.state = ST_RSTSEQ;
					d.cnt = 16'h0000;
					d.tile2Link = q.pins[PIN_TILE2];
					d.strapFault = |q.pins[PIN_LOW_C:PIN_LOW_A];
					d.postDiv = PLL_POST_DIV_BOOT;
					d.inDiv = PLL_IN_DIV_BOOT;
					case ({q.pins[PIN_SEL1], q.pins[PIN_SEL0]})
						2'b00:
						begin
							d.feedback = PLL_FB_SEL00;
							d.ratio = PLL_RATIO_SEL00;
						end
						2'b11:
						begin
							d.feedback = PLL_FB_SEL11;
							d.ratio = PLL_RATIO_SEL11;
						end
						2'b10:
						begin
							d.feedback = PLL_FB_SEL10;
							d.ratio = PLL_RATIO_SEL10;
						end
						default:
						begin
							d.feedback = PLL_FB_SEL01;
							d.ratio = PLL_RATIO_SEL01;
						end
					endcase
				end
			end
			ST_RSTSEQ:
			begin
				// Uses the short end of the allowed window so boot starts promptly.
				if (q.cnt == 16'(RESET_SEQ_CYC - 1))
				begin
					d.state = ST_SECREQ;
					d.otpReq = 1'b1;
				end
				else
				begin
					d.cnt = q.cnt + 16'h0001;
				end
			end
			ST_SECREQ:
			begin
				if (otpReadValid)
				begin
					d.secReg = otpReadData;
					d.otpReq = 1'b0;
					d.state = ST_CHOOSE;
				end
			end
			ST_CHOOSE:
			begin
				if (q.secReg[SECURE_BOOT_BIT])
				begin
					d.state = ST_RUN;
					d.fromOtp = 1'b1;
					d.run = 1'b1;
					d.coreResetN = 1'b1;
					d.gpioPd = 1'b0;
				end
				else
				begin
					d.state = ST_LEN;
					d.flashEn = 1'b1;
					d.byteCnt = 2'h0;
					d.crc = CRC_INIT;
					d.addr = '0;
				end
			end
			ST_LEN:
			begin
				if (flashByteValid)
				begin
					d.word = wordNext;
					d.crc = crcNext;
					d.byteCnt = q.byteCnt + 2'h1;
					if (q.byteCnt == 2'h3)
					begin
						d.wordsLeft = wordNext;
						if (wordNext > RAM_WORDS)
						begin
							d.state = ST_ERR;
							d.flashEn = 1'b0;
						end
						else if (wordNext == 32'h00000000)
						begin
							d.state = ST_TRAIL;
						end
						else
						begin
							d.state = ST_PROG;
						end
					end
				end
			end
			ST_PROG:
			begin
				if (flashByteValid)
				begin
					d.word = wordNext;
					d.crc = crcNext;
					d.byteCnt = q.byteCnt + 2'h1;
					if (q.byteCnt == 2'h3)
					begin
						d.ramWe = 1'b1;
						d.ramWaddr = q.addr;
						d.ramWdata = wordNext;
						d.addr = q.addr + 1'b1;
						d.wordsLeft = q.wordsLeft - 32'h00000001;
						if (q.wordsLeft == 32'h00000001)
						begin
							d.state = ST_TRAIL;
						end
					end
				end
			end
			ST_TRAIL:
			begin
				if (flashByteValid)
				begin
					d.word = wordNext;
					d.byteCnt = q.byteCnt + 2'h1;
					if (q.byteCnt == 2'h3)
					begin
						d.flashEn = 1'b0;
						if (wordNext == CRC_SKIP || wordNext == ~q.crc)
						begin
							d.state = ST_RUN;
							d.run = 1'b1;
							d.fromOtp = 1'b0;
							d.coreResetN = 1'b1;
							d.gpioPd = 1'b0;
						end
						else
						begin
							d.state = ST_ERR;
						end
					end
				end
			end
			ST_ERR:
			begin
				d.err = 1'b1;
			end
			ST_RUN:
			begin
				d.run = 1'b1;
			end
			default:
			begin
				d.state = ST_HOLD;
			end
		endcase
		// Pulling the chip reset low drops everything back to the held state.
		if (!q.pins[PIN_HOLD])
		begin
			d = LOADER_RESET;
			// Straps keep filtering while held, so leaving hold sees their present level.
			{d.sync3, d.sync2, d.sync1} = {q.sync2, q.sync1, pinRaw};
			d.pins = (q.sync2 & q.sync3) | (q.pins & (q.sync2 | q.sync3));
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= LOADER_RESET;
		end
		else
		begin
			q <= d;
		end
	end

	assign coreResetN = q.coreResetN;
	assign gpioPullDownEn = q.gpioPd;
	assign tile2LinkBoot = q.tile2Link;
	assign strapFault = q.strapFault;
	// The tile clock is osc*(feedback+1)/2/(input+1)/(post+1); these drive the PLL.
	assign pll_post_divider = q.postDiv;
	assign pll_feedback_value = q.feedback;
	assign pll_input_divider = q.inDiv;
	assign pllBootRatio = q.ratio;
	assign otpReadReq = q.otpReq;
	assign otpAddr = q.run ? OTP_EXEC_ADDR : OTP_SEC_ADDR;
	assign flashReadEn = q.flashEn;
	assign bootRun = q.run;
	assign bootFromOtp = q.fromOtp;
	assign execAddr = 32'h00000000;
	assign bootError = q.err;
	assign securityReg = q.secReg;
endmodule
`default_nettype wire

//--- verif/boot_loader_asserts.sv
// Port checker for the reset, PLL and boot loader block.
`timescale 1ns/1ps
`default_nettype none
module boot_loader_asserts (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Pins and PLL.
	input wire logic chip_hold_low_n,
	input wire logic pll_select_bit0,
	input wire logic pll_select_bit1,
	input wire logic pllCfgWe,
	input wire logic [2:0] pllCfgPostDivider,
	input wire logic [11:0] pllCfgFeedbackValue,
	input wire logic [5:0] pllCfgInputDivider,
	input wire logic [2:0] pll_post_divider,
	input wire logic [11:0] pll_feedback_value,
	input wire logic [5:0] pll_input_divider,
	input wire logic [5:0] pllBootRatio,
	// Boot state.
	input wire logic coreResetN,
	input wire logic gpioPullDownEn,
	input wire logic otpReadReq,
	input wire logic otpReadValid,
	input wire logic [31:0] otpReadData,
	input wire logic flashReadEn,
	input wire logic bootRun,
	input wire logic bootFromOtp,
	input wire logic bootError,
	input wire logic [31:0] execAddr,
	input wire logic [31:0] securityReg
);
	logic [15:0] seqCnt_q;
	logic [26:0] pllExp;
	// The count saturates so that a stuck sequence cannot wrap into the legal window.
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			seqCnt_q <= 16'h0000;
		else
			seqCnt_q <= !chip_hold_low_n ? 16'h0000 : seqCnt_q + {15'h0000, seqCnt_q != 16'hFFFF};
	always_comb
		case ({pll_select_bit1, pll_select_bit0})
			2'h0: pllExp = {6'h28, 12'h09F, 3'h1, 6'h00};
			2'h3: pllExp = {6'h10, 12'h03F, 3'h1, 6'h00};
			2'h2: pllExp = {6'h08, 12'h01F, 3'h1, 6'h00};
			default: pllExp = {6'h04, 12'h00F, 3'h1, 6'h00};
		endcase
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence secTaken;
		otpReadReq && otpReadValid;
	endsequence
	AST_HOLD_RESET: assert property ((!chip_hold_low_n) [*8] |-> !coreResetN && gpioPullDownEn)
		else $error("tile not held in reset");
	AST_SEQ_DELAY: assert property ($rose(otpReadReq) |-> seqCnt_q >= 16'h05DC && seqCnt_q <= 16'h3A98)
		else $error("reset sequence length out of range");
	AST_SEC_LOAD: assert property (secTaken |=> !otpReadReq && securityReg == $past(otpReadData))
		else $error("security word not loaded");
	AST_OTP_BOOT: assert property (secTaken ##0 otpReadData[5] |-> ##2 bootRun && bootFromOtp)
		else $error("secure boot not taken");
	AST_FLASH_BOOT: assert property (secTaken ##0 !otpReadData[5] |-> ##2 flashReadEn && !bootFromOtp)
		else $error("flash boot not taken");
	AST_RUN_LOW: assert property ($rose(bootRun) |-> execAddr == 32'h0 && coreResetN && !gpioPullDownEn)
		else $error("program start state wrong");
	AST_ERR_HOLD: assert property (bootError |-> !bootRun && !coreResetN)
		else $error("program started after boot error");
	AST_LOAD_END: assert property ($fell(flashReadEn) && chip_hold_low_n |-> ##[0:1] (bootRun || bootError))
		else $error("image end without verdict");
	AST_PLL_SEL: assert property (otpReadReq |-> {pllBootRatio, pll_feedback_value, pll_post_divider, pll_input_divider} == pllExp)
		else $error("pll start values wrong");
	AST_PLL_WRITE: assert property (pllCfgWe && coreResetN |=> pll_post_divider == $past(pllCfgPostDivider)
		&& pll_feedback_value == $past(pllCfgFeedbackValue) && pll_input_divider == $past(pllCfgInputDivider))
		else $error("pll write not applied");
endmodule
bind reset_pll_boot_loader boot_loader_asserts u_asserts (.clk_sys, .rst_n, .chip_hold_low_n,
	.pll_select_bit0, .pll_select_bit1, .pllCfgWe, .pllCfgPostDivider, .pllCfgFeedbackValue,
	.pllCfgInputDivider, .pll_post_divider, .pll_feedback_value, .pll_input_divider, .pllBootRatio,
	.coreResetN, .gpioPullDownEn, .otpReadReq, .otpReadValid, .otpReadData, .flashReadEn, .bootRun,
	.bootFromOtp, .bootError, .execAddr, .securityReg);
`default_nettype wire

//--- verif/flash_otp_model.sv
// Behavioural flash and OTP partner serving the boot image and security word.
`timescale 1ns/1ps
`default_nettype none
module flash_otp_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Scenario: secure word; mode 0 good, 1 skip, 2 bad trailer, 3 oversized length.
	input wire logic secure,
	input wire logic [1:0] trailerMode,
	// OTP side.
	input wire logic otpReadReq,
	input wire logic [10:0] otpAddr,
	output logic otpReadValid,
	output logic [31:0] otpReadData,
	// Flash side.
	input wire logic flashReadEn,
	output logic flashByteValid,
	output logic [7:0] flashByte
);
	logic [7:0] img [16];
	logic [31:0] crc;
	logic [4:0] idx;
	logic [4:0] nxt;
	logic give;
	logic [1:0] dly;
	always_comb
	begin
		img = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11,
			8'h96, 8'h0F, 8'hC3, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00};
		img[3] = trailerMode == 2'h3 ? 8'hFF : 8'h00;
		crc = 32'hFFFFFFFF;
		for (int i = 0; i < 12; i++)
		begin
			crc = crc ^ {24'h000000, img[i]};
			for (int b = 0; b < 8; b++)
				crc = crc[0] ? (crc >> 1) ^ 32'hEDB88320 : crc >> 1;
		end
		crc = trailerMode == 2'h1 ? 32'h0D15AB1E : ~crc ^ {31'h00000000, trailerMode[1]};
		for (int k = 0; k < 4; k++)
			img[12 + k] = crc[8 * k +: 8];
	end
	// Stalls on some bytes so that both prompt and slow delivery are seen.
	assign nxt = flashReadEn ? idx + {4'h0, flashByteValid} : 5'h00;
	assign give = flashReadEn && nxt < 5'h10 && !(flashByteValid && nxt[2]);
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			idx <= 5'h00;
			flashByteValid <= 1'b0;
			flashByte <= 8'h00;
			dly <= 2'h0;
			otpReadValid <= 1'b0;
			otpReadData <= 32'h00000000;
		end
		else
		begin
			idx <= nxt;
			flashByteValid <= give;
			flashByte <= give ? img[nxt[3:0]] : ~flashByte;
			dly <= otpReadReq && !otpReadValid ? dly + 2'h1 : 2'h0;
			otpReadValid <= otpReadReq && !otpReadValid && dly == 2'h3;
			if (otpReadReq && !otpReadValid && dly == 2'h3 && otpAddr == 11'h7FF)
				otpReadData <= {26'h2000000, secure, 5'h01};
			else
				otpReadData <= ~otpReadData;
		end
endmodule
`default_nettype wire

//--- verif/reset_pll_boot_loader_tb.sv
// Self-checking bench for the reset, PLL and boot loader block.
`timescale 1ns/1ps
`default_nettype none
module reset_pll_boot_loader_tb;
	localparam logic [1:0] SEL [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
	localparam logic [5:0] RATIO [4] = '{6'h28, 6'h10, 6'h08, 6'h04};
	localparam logic [11:0] FB [4] = '{12'h09F, 12'h03F, 12'h01F, 12'h00F};
	logic clk_sys = 1'b0, rst_n = 1'b0, chip_hold_low_n = 1'b0, secure = 1'b0, pllCfgWe = 1'b0;
	logic pll_select_bit0 = 1'b0, pll_select_bit1 = 1'b0, tile2_link_boot_strap = 1'b1;
	logic strap_low_a = 1'b0, strap_low_b = 1'b0, strap_low_c = 1'b0;
	logic [2:0] pllCfgPostDivider = 3'h0, pll_post_divider;
	logic [11:0] pllCfgFeedbackValue = 12'h000, pll_feedback_value;
	logic [5:0] pllCfgInputDivider = 6'h00, pll_input_divider, pllBootRatio;
	logic [1:0] trailerMode = 2'h0;
	logic [9:0] coreRdAddr = 10'h000;
	logic coreResetN, gpioPullDownEn, tile2LinkBoot, strapFault, otpReadReq, otpReadValid;
	logic flashReadEn, flashByteValid, bootRun, bootFromOtp, bootError, bad;
	logic [10:0] otpAddr;
	logic [7:0] flashByte;
	logic [31:0] otpReadData, execAddr, securityReg, coreRdData;
	int miscompares = 0, compares = 0;
	always #5 clk_sys = ~clk_sys;
	reset_pll_boot_loader u_dut (.clk_sys, .rst_n, .chip_hold_low_n, .pll_select_bit0,
		.pll_select_bit1, .tile2_link_boot_strap, .strap_low_a, .strap_low_b, .strap_low_c,
		.coreResetN, .gpioPullDownEn, .tile2LinkBoot, .strapFault, .pll_post_divider,
		.pll_feedback_value, .pll_input_divider, .pllBootRatio, .pllCfgWe, .pllCfgPostDivider,
		.pllCfgFeedbackValue, .pllCfgInputDivider, .otpReadReq, .otpAddr, .otpReadValid,
		.otpReadData, .flashReadEn, .flashByteValid, .flashByte, .bootRun, .bootFromOtp,
		.execAddr, .bootError, .securityReg, .coreRdAddr, .coreRdData);
	flash_otp_model u_partner (.clk_sys, .rst_n, .secure, .trailerMode, .otpReadReq, .otpAddr,
		.otpReadValid, .otpReadData, .flashReadEn, .flashByteValid, .flashByte);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic boot(input logic [1:0] sel, input logic sec, input logic [1:0] mode);
		@(negedge clk_sys);
		chip_hold_low_n = 1'b0;
		{pll_select_bit1, pll_select_bit0} = sel;
		secure = sec;
		trailerMode = mode;
		strap_low_a = mode[1];
		// The supply rail is taken as settled, so a short hold stands in for the long one.
		repeat (8) @(negedge clk_sys);
		check(coreResetN, 32'h0);
		check(gpioPullDownEn, 32'h1);
		check(otpAddr, 32'h7FF);
		chip_hold_low_n = 1'b1;
		for (int i = 0; i < 20000 && !(bootRun === 1'b1 || bootError === 1'b1); i++)
			@(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
	endtask
	initial
	begin
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int t = 0; t < 5; t++)
		begin
			bad = t == 2 || t == 3;
			boot(SEL[t % 4], t == 4, t == 3 ? 2'h3 : t == 2 ? 2'h2 : {1'b0, t == 1});
			check(pllBootRatio, RATIO[t % 4]);
			check(pll_feedback_value, FB[t % 4]);
			check({pll_post_divider, pll_input_divider}, {3'h1, 6'h00});
			check(bootError, bad);
			check(bootRun, !bad);
			check({coreResetN, gpioPullDownEn, flashReadEn}, {29'h0, !bad, bad, 1'b0});
			check(bootFromOtp, t == 4);
			check(securityReg[5], t == 4);
			check(otpAddr, bad ? 32'h7FF : 32'h0);
			check(execAddr, 32'h0);
			check(strapFault, bad);
			check(tile2LinkBoot, 32'h1);
			for (int a = 0; a < 2 && t < 2; a++)
			begin
				coreRdAddr = a[9:0];
				@(negedge clk_sys);
				check(coreRdData, a ? 32'hA5C30F96 : 32'h11223344);
			end
			$display("boot test %0d done", t);
		end
		pllCfgPostDivider = 3'h7;
		pllCfgFeedbackValue = 12'hFFF;
		pllCfgInputDivider = 6'h3F;
		// Software retunes after boot with every field inside its legal range.
		pllCfgWe = 1'b1;
		@(negedge clk_sys);
		pllCfgWe = 1'b0;
		@(negedge clk_sys);
		check({pll_post_divider, pll_feedback_value, pll_input_divider}, {3'h7, 12'hFFF, 6'h3F});
		$display("pll write test done");
		finish_test();
	end
	// Five boots take about 8000 cycles; the limit leaves ample margin.
	initial
	begin
		#400000;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
